// ### logic/ois_pkg.sv
`default_nettype none
package ois_pkg;
  localparam int unsigned OIS_IN_W = 8;
  localparam int unsigned OIS_FRAME_W = 16;
  localparam int unsigned OIS_CRC_W = 5;
  localparam int unsigned OIS_SYNC_STAGES = 2;
  // CRC generator x^5 + x^4 + x^2 + 1, top term implied.
  localparam logic [4:0] OIS_CRC_POLY = 5'h15;
  localparam logic [4:0] OIS_CRC_INIT = 5'h00;
  localparam logic OIS_SUPPLY_OK = 1'b1;
  localparam logic OIS_SUPPLY_LOW = 1'b0;
  localparam logic OIS_TEMP_OK = 1'b0;
  localparam logic OIS_TEMP_ALARM = 1'b1;
  localparam logic OIS_FAULT_ACTIVE_N = 1'b0;
  localparam logic OIS_FAULT_IDLE_N = 1'b1;
  // Link pins after synchronisation.
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic cascade;
  } ois_link_t;
  // Analog monitor results, already as flag levels.
  typedef struct packed {
    logic supply_low;
    logic supply_warn;
    logic over_temp;
  } ois_mon_t;
  typedef enum logic [1:0] {
    OIS_IDLE = 2'b00,
    OIS_SHIFT = 2'b01
  } ois_state_t;
endpackage
`default_nettype wire

// ### logic/ois_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ois_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("ois_fifo depth must be a power of two of at least 2");
    end
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  assign in_ready_o = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid_o = wr_q != rd_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/ois_serializer.sv
`timescale 1ns/100ps
`default_nettype none
module ois_serializer
  import ois_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Link pins.
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic serial_in_cascade_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  // Configuration and monitors.
  input wire logic frame_length_select_i,
  input wire logic regulator_powered_i,
  input wire logic [OIS_IN_W-1:0] field_input_i,
  input wire logic supply_below_primary_i,
  input wire logic supply_below_secondary_i,
  input wire logic temp_above_alarm_i,
  // Snapshot stream and status.
  output logic snap_valid_o,
  input wire logic snap_ready_i,
  output logic [OIS_IN_W-1:0] snap_data_o,
  output logic fault_n_o,
  output logic busy_o
);
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("ois_serializer needs a FIFO depth of at least 2");
    end
    if (OIS_FRAME_W != OIS_IN_W + OIS_CRC_W + $bits(ois_mon_t)) begin
      $error("ois_serializer frame must hold the inputs, the CRC and three flags");
    end
    if (OIS_SYNC_STAGES != 2) begin
      $error("ois_serializer synchronisers are built with two stages");
    end
  end

  function automatic logic [4:0] crc_step(input logic [4:0] c, input logic b);
    logic fb;
    fb = c[4] ^ b;
    crc_step = {c[3:0], 1'b0} ^ (fb ? OIS_CRC_POLY : 5'h00);
  endfunction

  function automatic logic [4:0] crc_byte(input logic [OIS_IN_W-1:0] d);
    logic [4:0] c;
    c = OIS_CRC_INIT;
    for (int i = OIS_IN_W - 1; i >= 0; i--) begin
      c = crc_step(c, d[i]);
    end
    crc_byte = c;
  endfunction

  function automatic logic in_frame(input ois_state_t s);
    case (s)
      OIS_SHIFT: in_frame = 1'b1;
      default: in_frame = 1'b0;
    endcase
  endfunction

  // Two-stage synchronisers; only the second stage is read. They reset to the
  // idle pin levels so that no false select or clock edge follows the release.
  localparam int unsigned LINK_W = $bits(ois_link_t);
  localparam ois_link_t LINK_IDLE = '{cs_n: 1'b1, sclk: 1'b0, cascade: 1'b0};
  logic [LINK_W-1:0] pins;
  logic [LINK_W-1:0] synced;
  ois_link_t link;
  logic sclk_prev_q;
  logic cs_prev_q;
  assign pins = {cs_n_i, sclk_i, serial_in_cascade_i};
  for (genvar g = 0; g < LINK_W; g++) begin : g_sync
    logic s1_q;
    logic s2_q;
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        s1_q <= LINK_IDLE[g];
        s2_q <= LINK_IDLE[g];
      end else begin
        s1_q <= pins[g];
        s2_q <= s1_q;
      end
    end
    assign synced[g] = s2_q;
  end
  assign link = ois_link_t'(synced);

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= link.sclk;
      cs_prev_q <= link.cs_n;
    end
  end
  logic cs_fall;
  logic sclk_fall;
  assign cs_fall = cs_prev_q && !link.cs_n;
  assign sclk_fall = sclk_prev_q && !link.sclk && !link.cs_n;

  // Monitor flags.
  ois_mon_t mon;
  always_comb begin
    mon.supply_low = (supply_below_primary_i || regulator_powered_i)
                     ? OIS_SUPPLY_LOW : OIS_SUPPLY_OK;
    mon.supply_warn = (supply_below_secondary_i || regulator_powered_i)
                      ? OIS_SUPPLY_LOW : OIS_SUPPLY_OK;
    mon.over_temp = temp_above_alarm_i ? OIS_TEMP_ALARM : OIS_TEMP_OK;
  end

  // Input snapshots pass through a FIFO; when it is full the snapshot is
  // dropped, but the frame itself is never stalled by the consumer.
  logic fifo_in_ready;
  ois_fifo #(
    .WIDTH(OIS_IN_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(cs_fall),
    .in_ready_o(fifo_in_ready),
    .in_data_i(field_input_i),
    .out_valid_o(snap_valid_o),
    .out_ready_i(snap_ready_i),
    .out_data_o(snap_data_o)
  );

  // Frame shift register; the select edge loads the frame and each falling clock edge shifts in the cascade pin.
  ois_state_t state_q;
  logic [OIS_FRAME_W-1:0] shift_q;
  logic [OIS_FRAME_W-1:0] frame;
  always_comb begin
    if (frame_length_select_i) begin
      frame = {field_input_i, {OIS_IN_W{1'b0}}};
    end else begin
      frame = {field_input_i, crc_byte(field_input_i),
               mon.supply_low, mon.over_temp, mon.supply_warn};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q <= OIS_IDLE;
    end else begin
      case (state_q)
        OIS_IDLE: begin
          if (cs_fall) begin
            state_q <= OIS_SHIFT;
          end
        end
        OIS_SHIFT: begin
          if (link.cs_n) begin
            state_q <= OIS_IDLE;
          end
        end
        default: begin
          state_q <= OIS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      shift_q <= '0;
    end else if (cs_fall) begin
      shift_q <= frame;
    end else if (sclk_fall && in_frame(state_q)) begin
      shift_q <= {shift_q[OIS_FRAME_W-2:0], link.cascade};
    end
  end

  // Drive comes on in the select-fall cycle from the frame itself, so the
  // first bit does not wait for the register load.
  always_comb begin
    serial_out_oe_o = !link.cs_n;
    if (cs_fall) begin
      serial_out_o = frame[OIS_FRAME_W-1];
    end else if (!link.cs_n) begin
      serial_out_o = shift_q[OIS_FRAME_W-1];
    end else begin
      serial_out_o = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      fault_n_o <= OIS_FAULT_IDLE_N;
    end else begin
      fault_n_o <= (regulator_powered_i || supply_below_primary_i)
                   ? OIS_FAULT_ACTIVE_N : OIS_FAULT_IDLE_N;
    end
  end

  assign busy_o = in_frame(state_q) && !fifo_in_ready;
endmodule
`default_nettype wire

// ### tb/ois_serializer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ois_props (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Watched pins.
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic regulator_powered_i,
  input wire logic supply_below_primary_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic snap_valid_o,
  input wire logic fault_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_oe_drive: assert property (!cs_n_i [*4] |=> serial_out_oe_o) else $error("oe late");
  a_oe_release: assert property (cs_n_i [*4] |=> !serial_out_oe_o) else $error("oe stuck");
  a_oe_fall_cause: assert property ($fell(serial_out_oe_o) |-> $past(cs_n_i, 2))
    else $error("oe dropped");
  a_idle_low: assert property (!serial_out_oe_o |-> !serial_out_o) else $error("idle data");
  a_bit_hold: assert property ((serial_out_oe_o && $stable(sclk_i)) [*6] |->
    $stable(serial_out_o)) else $error("bit moved");
  a_snap_take: assert property ($fell(cs_n_i) |-> ##[2:6] snap_valid_o)
    else $error("no snapshot");
  a_fault_held: assert property (regulator_powered_i [*3] |=> !fault_n_o)
    else $error("fault high");
  a_fault_clear: assert property ((!regulator_powered_i && !supply_below_primary_i) [*3]
    |=> fault_n_o) else $error("fault low");
endmodule
bind ois_serializer ois_props u_props (.ref_clk_i, .reset_n_i, .cs_n_i, .sclk_i,
  .regulator_powered_i, .supply_below_primary_i, .serial_out_o, .serial_out_oe_o,
  .snap_valid_o, .fault_n_o);
`default_nettype wire

// ### tb/ois_spi_master.sv
`timescale 1ns/100ps
`default_nettype none
module ois_spi_master (
  // Request and result.
  input wire logic go_i,
  input wire logic [5:0] nbits_i,
  input wire logic [15:0] casc_i,
  output logic [31:0] rx_o,
  output logic done_o,
  // Link pins.
  output logic cs_n_o,
  output logic sclk_o,
  output logic casc_o,
  input wire logic miso_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    casc_o = 1'b0;
    done_o = 1'b0;
    rx_o = '0;
  end
  // Low phase is longer so the synced data has settled before the sampling edge.
  always @(posedge go_i) begin
    done_o = 1'b0;
    // Pin changes land between clock edges, so every sampler sees one order.
    #5;
    cs_n_o = 1'b0;
    #200;
    for (int i = 0; i < nbits_i; i++) begin
      casc_o = casc_i[15 - i % 16];
      sclk_o = 1'b1;
      rx_o = {rx_o[30:0], miso_i};
      #60;
      sclk_o = 1'b0;
      #100;
    end
    cs_n_o = 1'b1;
    casc_o = ~casc_o;
    done_o = 1'b1;
  end
endmodule
`default_nettype wire

// ### tb/ois_serializer_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module ois_serializer_test;
  import ois_pkg::*;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, frame_length_select_i = 1'b0;
  logic regulator_powered_i = 1'b0, supply_below_primary_i = 1'b0, snap_ready_i = 1'b0;
  logic supply_below_secondary_i = 1'b0, temp_above_alarm_i = 1'b0, go = 1'b0;
  logic [7:0] field_input_i = 8'h00;
  logic cs_n_i, sclk_i, serial_in_cascade_i, serial_out_o, serial_out_oe_o;
  logic snap_valid_o, fault_n_o, busy_o, done;
  logic [7:0] snap_data_o;
  logic [31:0] rx;
  logic [5:0] nb = 6'h20;
  logic [12:0] rows [8];
  int miscompares = 0, n_tests = 0, cyc = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  ois_serializer dut (.ref_clk_i, .reset_n_i, .cs_n_i, .sclk_i, .serial_in_cascade_i,
    .serial_out_o, .serial_out_oe_o, .frame_length_select_i, .regulator_powered_i,
    .field_input_i, .supply_below_primary_i, .supply_below_secondary_i,
    .temp_above_alarm_i, .snap_valid_o, .snap_ready_i, .snap_data_o, .fault_n_o, .busy_o);
  ois_spi_master host (.go_i(go), .nbits_i(nb), .casc_i(16'hc3a5), .rx_o(rx),
    .done_o(done), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .casc_o(serial_in_cascade_i),
    .miso_i(serial_out_oe_o ? serial_out_o : ~rx[0]));
  function automatic logic [15:0] frame(input logic [12:0] r);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 7; i >= 0; i--) c = {c[3:0], 1'b0} ^ ((c[4] ^ r[i]) ? 5'h15 : 5'h00);
    return {r[7:0], c, ~(r[11] | r[10]), r[8], ~(r[11] | r[9])};
  endfunction
  task automatic xfer(input logic [5:0] n, input logic exp_busy);
    nb = n;
    @(posedge ref_clk_i) go <= 1'b1;
    @(posedge ref_clk_i) go <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1 `CHK("busy", exp_busy, busy_o)
    repeat (2000) if (done !== 1'b1) @(posedge ref_clk_i);
    repeat (8) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic summarize();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rows = '{13'h00a5, 13'h043c, 13'h03ff, 13'h0801, 13'h1096, 13'h0000, 13'h0e5a, 13'h1c7e};
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    #1 `CHK("oe", 1'b0, serial_out_oe_o)
    foreach (rows[k]) begin
      @(posedge ref_clk_i) {frame_length_select_i, regulator_powered_i, supply_below_primary_i,
        supply_below_secondary_i, temp_above_alarm_i, field_input_i} <= rows[k];
      xfer(6'h20, k == 7);
      if (rows[k][12]) `CHK("byte", rows[k][7:0], rx[31:24])
      else `CHK("frame", {frame(rows[k]), 16'hc3a5}, rx)
      `CHK("fault_n", ~(rows[k][11] | rows[k][10]), fault_n_o)
    end
    // An aborted frame must not disturb the next one, and both overflow the full FIFO.
    @(posedge ref_clk_i) {frame_length_select_i, regulator_powered_i, supply_below_primary_i,
      supply_below_secondary_i, temp_above_alarm_i, field_input_i} <= 13'h0055;
    xfer(6'h05, 1'b1);
    xfer(6'h10, 1'b1);
    `CHK("restart", frame(13'h0055), rx[15:0])
    foreach (rows[k]) begin
      `CHK("snap", {1'b1, rows[k][7:0]}, {snap_valid_o, snap_data_o})
      @(posedge ref_clk_i) snap_ready_i <= 1'b1;
      @(posedge ref_clk_i) snap_ready_i <= 1'b0;
      #1;
    end
    `CHK("empty", 1'b0, snap_valid_o)
    // A reset in mid-run empties the snapshot queue and releases the fault output.
    @(posedge ref_clk_i) regulator_powered_i <= 1'b1;
    xfer(6'h08, 1'b0);
    `CHK("queued", 1'b1, snap_valid_o)
    `CHK("fault_reg", 1'b0, fault_n_o)
    @(posedge ref_clk_i) reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK("rst_snap", 1'b0, snap_valid_o)
    `CHK("rst_fault", 1'b1, fault_n_o)
    @(posedge ref_clk_i) reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("rst_oe", 1'b0, serial_out_oe_o)
    `CHK("rst_fault_again", 1'b0, fault_n_o)
    summarize();
  end
endmodule
`default_nettype wire
